/* ufbc_pkg.sv */
// constants, register map and types of the serial frame and baud block
package ufbc_pkg;
    // ==========================================================
    // register map, one register per aligned word, the data register nine bits wide
    localparam logic [7:0] OFS_MODE      = 8'h00;
    localparam logic [7:0] OFS_CTRL_B    = 8'h04;
    localparam logic [7:0] OFS_CTRL_C    = 8'h08;
    localparam logic [7:0] OFS_DIV_UPPER = 8'h0C;
    localparam logic [7:0] OFS_DIV_LOWER = 8'h10;
    localparam logic [7:0] OFS_DATA      = 8'h14;
    localparam logic [7:0] OFS_STATUS    = 8'h18;
    // ==========================================================
    // field positions
    localparam int MODE_DBL  = 1;
    localparam int CB_RX_EN  = 4;
    localparam int CB_TX_EN  = 3;
    localparam int CB_CHR2   = 2;
    localparam int CC_SYNC   = 6;
    localparam int CC_STOP   = 3;
    localparam int CC_CHR_HI = 2;
    localparam int CC_CHR_LO = 1;
    localparam int CC_POL    = 0;
    localparam int DATA_W    = 9;
    localparam int DIV_W     = 12;
    localparam int LOWER_W   = 8;
    localparam int UPPER_W   = DIV_W - LOWER_W;
    // ==========================================================
    // reset values
    localparam logic [1:0]       CHR_LOW_RST = 2'h3;
    localparam logic [DIV_W-1:0] DIV_RST     = 12'h000;
    // ==========================================================
    // character size codes and lengths
    localparam logic [2:0] CHR_5 = 3'h0;
    localparam logic [2:0] CHR_6 = 3'h1;
    localparam logic [2:0] CHR_7 = 3'h2;
    localparam logic [2:0] CHR_8 = 3'h3;
    localparam logic [2:0] CHR_9 = 3'h7;
    localparam logic [3:0] LEN_5 = 4'h5;
    localparam logic [3:0] LEN_6 = 4'h6;
    localparam logic [3:0] LEN_7 = 4'h7;
    localparam logic [3:0] LEN_8 = 4'h8;
    localparam logic [3:0] LEN_9 = 4'h9;
    // ==========================================================
    // oversampling phases: last and middle tick of one bit
    localparam logic [3:0] PH_LAST_NORM = 4'hF;
    localparam logic [3:0] PH_LAST_DBL  = 4'h7;
    localparam logic [3:0] PH_MID_NORM  = 4'h7;
    localparam logic [3:0] PH_MID_DBL   = 4'h3;
    // ==========================================================
    // frame state machine
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_START = 4'h2,
        ST_DATA  = 4'h4,
        ST_STOP  = 4'h8
    } ufbc_state_type;
endpackage

/* ufbc_frame_baud.sv */
// frame format, baud divisor and serial frame engine with wishbone slave
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - transmitter sends one stop bit when select is 0, two when 1.
// - size field selects 5,6,7,8 or 9 data bits; other codes reserved.
// - sync polarity 0 drives data on rising clock, samples on falling.
// - 12-bit divisor, upper register four msbs, lower register eight lsbs.
// - upper four bits of divisor upper read zero; software writes zeros.
// - lower byte write reloads prescaler at once; upper write does not.
// - divisor zero gives oscillator over 16, or over 8 at double speed.
// - double speed cuts per-bit divisor 16 to 8, asynchronous only.
// - receiver checks only the first stop bit, ignoring the count.
module ufbc_frame_baud (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        rxdPin,
    output logic             txdPin,
    output logic             txdOe,
    output logic             syncSerialClockPin,
    output logic             syncSerialClockOe
);
    import ufbc_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic                 dbl;
        logic                 rxEn;
        logic                 txEn;
        logic                 chr2;
        logic                 syncMode;
        logic                 stopSel;
        logic [1:0]           chrLow;
        logic                 pol;
        logic [DIV_W-1:0]     div;
        logic [DIV_W-1:0]     presc;
        logic                 sync_serial_clock_pin;
        ufbc_state_type       txSt;
        logic [3:0]           txPhase;
        logic [3:0]           txCnt;
        logic [DATA_W-1:0]    txShift;
        logic [DATA_W-1:0]    txData;
        logic                 txPend;
        logic                 txStopLeft;
        logic                 txOut;
        ufbc_state_type       rxSt;
        logic [3:0]           rxPhase;
        logic [3:0]           rxIdx;
        logic [DATA_W-1:0]    rxShift;
        logic [DATA_W-1:0]    rxData;
        logic                 rxFull;
        logic                 rxFrameErr;
        logic                 ack;
        logic [31:0]          rdat;
    } ufbc_regs_type;

    localparam ufbc_regs_type REGS_RST = '{
        chrLow  : CHR_LOW_RST,
        div     : DIV_RST,
        presc   : DIV_RST,
        txSt    : ST_IDLE,
        rxSt    : ST_IDLE,
        txOut   : 1'b1,
        default : '0
    };

    ufbc_regs_type r;
    ufbc_regs_type n;

    // reserved codes fall back to eight bits so frames stay well formed
    function automatic logic [3:0] chrBits(input logic [2:0] code);
        case (code)
            CHR_5:   chrBits = LEN_5;
            CHR_6:   chrBits = LEN_6;
            CHR_7:   chrBits = LEN_7;
            CHR_8:   chrBits = LEN_8;
            CHR_9:   chrBits = LEN_9;
            default: chrBits = LEN_8;
        endcase
    endfunction

    logic             acc;
    logic             wr;
    logic             tick;
    logic             rise;
    logic             fall;
    logic             txEdge;
    logic             rxEdge;
    logic             txBitEnd;
    logic             rxSample;
    logic [3:0]       phLast;
    logic [3:0]       phMid;
    logic [3:0]       bits;

    // ==========================================================
    // next state
    always_comb begin
        n        = r;
        acc      = wb_cyc_i && wb_stb_i && !r.ack;
        wr       = acc && wb_we_i && wb_sel_i[0];
        n.ack    = acc;
        bits     = chrBits({r.chr2, r.chrLow});
        // prescaler ticks every divisor plus one clocks
        tick     = (r.presc == DIV_RST);
        n.presc  = tick ? r.div : r.presc - 12'h001;
        // double speed only shortens asynchronous bits
        phLast   = r.dbl ? PH_LAST_DBL : PH_LAST_NORM;
        phMid    = r.dbl ? PH_MID_DBL : PH_MID_NORM;
        // synchronous clock: one half period per prescaler tick
        rise     = tick && r.syncMode && !r.sync_serial_clock_pin;
        fall     = tick && r.syncMode && r.sync_serial_clock_pin;
        // polarity is only looked at in synchronous mode
        txEdge   = r.pol ? fall : rise;
        rxEdge   = r.pol ? rise : fall;
        if (!r.syncMode) begin
            n.sync_serial_clock_pin = 1'b0;
        end else if (tick) begin
            n.sync_serial_clock_pin = !r.sync_serial_clock_pin;
        end
        txBitEnd = r.syncMode ? txEdge : (tick && r.txPhase == phLast);
        if (tick && !r.syncMode) begin
            n.txPhase = txBitEnd ? 4'h0 : r.txPhase + 4'h1;
        end

        // ======================================================
        // transmitter
        case (r.txSt)
            ST_IDLE: begin
                if (r.txPend && r.txEn && txBitEnd) begin
                    n.txSt    = ST_START;
                    n.txOut   = 1'b0;
                    n.txShift = r.txData;
                    n.txCnt   = bits;
                    n.txPend  = 1'b0;
                end
            end
            ST_START, ST_DATA: begin
                if (txBitEnd) begin
                    if (r.txCnt == 4'h0) begin
                        n.txSt       = ST_STOP;
                        n.txOut      = 1'b1;
                        n.txStopLeft = r.stopSel;
                    end else begin
                        n.txSt    = ST_DATA;
                        n.txOut   = r.txShift[0];
                        n.txShift = r.txShift >> 1;
                        n.txCnt   = r.txCnt - 4'h1;
                    end
                end
            end
            ST_STOP: begin
                if (txBitEnd) begin
                    if (r.txStopLeft) begin
                        n.txStopLeft = 1'b0;
                    end else if (r.txPend && r.txEn) begin
                        // back to back: no idle bit after the last stop bit
                        n.txSt    = ST_START;
                        n.txOut   = 1'b0;
                        n.txShift = r.txData;
                        n.txCnt   = bits;
                        n.txPend  = 1'b0;
                    end else begin
                        n.txSt = ST_IDLE;
                    end
                end
            end
            default: begin
                n.txSt  = ST_IDLE;
                n.txOut = 1'b1;
            end
        endcase

        // ======================================================
        // bus access; a write of tx data wins over a frame start
        n.rdat = '0;
        if (acc && !wb_we_i) begin
            case (wb_adr_i)
                OFS_MODE:      n.rdat[MODE_DBL] = r.dbl;
                OFS_CTRL_B: begin
                    n.rdat[CB_RX_EN] = r.rxEn;
                    n.rdat[CB_TX_EN] = r.txEn;
                    n.rdat[CB_CHR2]  = r.chr2;
                end
                OFS_CTRL_C: begin
                    n.rdat[CC_SYNC]              = r.syncMode;
                    n.rdat[CC_STOP]              = r.stopSel;
                    n.rdat[CC_CHR_HI:CC_CHR_LO]  = r.chrLow;
                    n.rdat[CC_POL]               = r.pol;
                end
                // upper bits of the high byte read as zero
                OFS_DIV_UPPER: n.rdat[UPPER_W-1:0] = r.div[DIV_W-1:LOWER_W];
                OFS_DIV_LOWER: n.rdat[LOWER_W-1:0] = r.div[LOWER_W-1:0];
                OFS_DATA: begin
                    n.rdat[DATA_W-1:0] = r.rxData;
                    n.rxFull           = 1'b0;
                end
                OFS_STATUS: n.rdat[4:0] = {r.rxFrameErr, r.rxFull, r.txPend,
                                           r.txSt != ST_IDLE,
                                           r.rxSt != ST_IDLE};
                default:    n.rdat = '0;
            endcase
        end
        if (wr) begin
            case (wb_adr_i)
                OFS_MODE:   n.dbl = wb_dat_i[MODE_DBL];
                OFS_CTRL_B: begin
                    n.rxEn = wb_dat_i[CB_RX_EN];
                    n.txEn = wb_dat_i[CB_TX_EN];
                    n.chr2 = wb_dat_i[CB_CHR2];
                end
                OFS_CTRL_C: begin
                    n.syncMode = wb_dat_i[CC_SYNC];
                    n.stopSel  = wb_dat_i[CC_STOP];
                    n.chrLow   = wb_dat_i[CC_CHR_HI:CC_CHR_LO];
                    n.pol      = wb_dat_i[CC_POL];
                end
                // upper byte alone leaves the running prescaler alone;
                // frames in flight are not protected from a new rate
                OFS_DIV_UPPER: n.div[DIV_W-1:LOWER_W] = wb_dat_i[UPPER_W-1:0];
                OFS_DIV_LOWER: begin
                    n.div[LOWER_W-1:0] = wb_dat_i[LOWER_W-1:0];
                    n.presc = {r.div[DIV_W-1:LOWER_W],
                               wb_dat_i[LOWER_W-1:0]};
                end
                OFS_DATA: begin
                    n.txData = wb_dat_i[DATA_W-1:0];
                    n.txPend = 1'b1;
                end
                default: n.txPend = n.txPend;
            endcase
        end

        // ======================================================
        // receiver; a completed frame wins over a data read
        rxSample = r.syncMode ? rxEdge : (tick && r.rxPhase == phLast);
        if (tick && !r.syncMode) begin
            n.rxPhase = r.rxPhase + 4'h1;
        end
        case (r.rxSt)
            ST_IDLE: begin
                n.rxIdx = 4'h0;
                if (r.syncMode ? (rxEdge && !rxdPin) : (tick && !rxdPin)) begin
                    n.rxSt    = r.syncMode ? ST_DATA : ST_START;
                    n.rxPhase = 4'h0;
                end
            end
            ST_START: begin
                // recheck the start bit in its middle to reject glitches
                if (tick && r.rxPhase == phMid) begin
                    n.rxSt    = rxdPin ? ST_IDLE : ST_DATA;
                    n.rxPhase = 4'h0;
                end
            end
            ST_DATA: begin
                if (rxSample && r.rxPhase == phLast) begin
                    n.rxPhase = 4'h0;
                end
                if (rxSample) begin
                    if (r.rxIdx == bits) begin
                        // only the first stop bit is looked at
                        n.rxFrameErr = !rxdPin;
                        n.rxData     = r.rxShift;
                        n.rxFull     = 1'b1;
                        n.rxSt       = ST_IDLE;
                    end else begin
                        n.rxShift[r.rxIdx] = rxdPin;
                        n.rxIdx            = r.rxIdx + 4'h1;
                    end
                end
            end
            default: n.rxSt = ST_IDLE;
        endcase
        if (r.rxSt == ST_IDLE && rxSample == 1'b0 && r.rxIdx == 4'h0) begin
            n.rxShift = r.rxShift;
        end
        if (!r.rxEn) begin
            n.rxSt = ST_IDLE;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= REGS_RST;
        end else begin
            r <= n;
        end
    end

    assign wb_dat_o           = r.rdat;
    assign wb_ack_o           = r.ack;
    assign txdPin             = r.txOut;
    assign txdOe              = r.txEn;
    assign syncSerialClockPin = r.sync_serial_clock_pin;
    assign syncSerialClockOe  = r.syncMode && (r.txEn || r.rxEn);
endmodule

`default_nettype wire

/* ufbc_frame_baud_props.sv */
// port assertions of the serial frame and baud block
`timescale 1ns/1ps
`default_nettype none
module ufbc_props
    import ufbc_pkg::*;
(
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        rxdPin,
    input wire logic        txdPin,
    input wire logic        txdOe,
    input wire logic        syncSerialClockPin,
    input wire logic        syncSerialClockOe
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // ========
    // register bus
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack wider than one cycle");
    property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_due: assert property (p_ack_due)
        else $error("request not answered next cycle");
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    property p_dat_quiet; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_quiet: assert property (p_dat_quiet)
        else $error("read data outside ack");
    property p_upper_zero;
        wb_ack_o && !wb_we_i && wb_adr_i == OFS_DIV_UPPER
            |-> wb_dat_o[31:4] == 28'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("divisor upper reads nonzero high bits");
    // ========
    // serial line
    property p_sync_edge;
        syncSerialClockOe && $changed(txdPin)
            |-> $changed(syncSerialClockPin);
    endproperty
    a_sync_edge: assert property (p_sync_edge)
        else $error("sync data moved off a clock edge");
    property p_start_en; $fell(txdPin) |-> txdOe; endproperty
    a_start_en: assert property (p_start_en)
        else $error("frame started with transmitter off");
    property p_start_len; $fell(txdPin) |-> !txdPin [*2]; endproperty
    a_start_len: assert property (p_start_len)
        else $error("start bit too short");
endmodule

bind ufbc_frame_baud ufbc_props u_props (
    .mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rxdPin(rxdPin), .txdPin(txdPin), .txdOe(txdOe),
    .syncSerialClockPin(syncSerialClockPin),
    .syncSerialClockOe(syncSerialClockOe));
`default_nettype wire

/* ufbc_remote.sv */
// remote serial transceiver facing the block's line pins
`timescale 1ns/1ps
`default_nettype none
module ufbc_remote (
    input  wire logic mclk,
    input  wire logic txdPin,
    input  wire logic syncSerialClockPin,
    output logic      rxdLine
);
    int cnt = 0;
    initial rxdLine = 1'b1;
    always @(posedge mclk) cnt <= cnt + 1;
    // async frame in: start, lsb first, one stop, then idle high
    task automatic send(input logic [8:0] ch, input int nb, input int per,
                        input logic stopLvl);
        for (int i = -1; i <= nb; i++) begin
            rxdLine <= (i < 0) ? 1'b0 : (i < nb) ? ch[i] : stopLvl;
            repeat (per) @(posedge mclk);
        end
        rxdLine <= 1'b1;
    endtask
    // bit period taken from the start bit, so data bit 0 must be 1
    task automatic recv(input int nb, output logic [8:0] d, output int per,
                        output int t0, output logic stp);
        d = 9'h000;
        per = 0;
        do @(posedge mclk); while (txdPin !== 1'b0);
        t0 = cnt;
        do begin
            @(posedge mclk);
            per++;
        end while (txdPin === 1'b0);
        repeat (per / 2) @(posedge mclk);
        for (int i = 0; i < nb; i++) begin
            d[i] = txdPin;
            repeat (per) @(posedge mclk);
        end
        stp = txdPin;
    endtask
    // sync frame out: sample on falling clock for pol 0, rising for 1
    task automatic srecv(input logic pol, input int nb, output logic [8:0] d);
        logic prev;
        int   i;
        d = 9'h000;
        i = -1;
        prev = syncSerialClockPin;
        while (i < nb) begin
            @(posedge mclk);
            if (syncSerialClockPin !== prev && syncSerialClockPin === pol) begin
                if (i >= 0) d[i] = txdPin;
                if (i >= 0 || txdPin === 1'b0) i++;
            end
            prev = syncSerialClockPin;
        end
    endtask
endmodule
`default_nettype wire

/* ufbc_frame_baud_tb.sv */
// self-checking bench of the serial frame and baud block
`timescale 1ns/1ps
`default_nettype none
module ufbc_frame_baud_tb;
    import ufbc_pkg::*;
    logic        mclk = 1'b0;
    logic        sysRst = 1'b1;
    logic        wbCyc = 1'b0;
    logic        wbStb = 1'b0;
    logic        wbWe = 1'b0;
    logic [7:0]  wbAdr = 8'h00;
    logic [31:0] wbDatW = 32'h0;
    logic [31:0] wbDatR;
    logic        wbAck, rxdLine, txdPin, txdOe, sclk, sclkOe, stp;
    logic [8:0]  q, got;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          per, t0, t1;
    logic [2:0]  cs [5] = '{CHR_5, CHR_6, CHR_7, CHR_8, CHR_9};
    logic [3:0]  ln [5] = '{LEN_5, LEN_6, LEN_7, LEN_8, LEN_9};
    int          ex [3] = '{48, 24, 8};
    logic        dbl [3] = '{1'b0, 1'b1, 1'b1};
    logic        sb [3] = '{1'b0, 1'b1, 1'b0};
    logic [8:0]  lo [3] = '{9'h002, 9'h002, 9'h000};

    initial forever #2 mclk = ~mclk;
    ufbc_frame_baud DUT (
        .mclk(mclk), .sys_rst(sysRst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
        .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
        .rxdPin(rxdLine), .txdPin(txdPin), .txdOe(txdOe),
        .syncSerialClockPin(sclk), .syncSerialClockOe(sclkOe));
    ufbc_remote remote (.mclk(mclk), .txdPin(txdPin),
        .syncSerialClockPin(sclk), .rxdLine(rxdLine));
    // ========
    // bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [8:0] d,
                      output logic [8:0] r);
        int t;
        t = 0;
        @(posedge mclk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbDatW <= {23'h0, d};
        do begin
            @(posedge mclk);
            t++;
        end while (wbAck !== 1'b1 && t < 64);
        if (t >= 64) chk(1'b0, 1'b1);
        r = wbDatR[8:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [8:0] e);
        wb(1'b0, a, 9'h000, q);
        chk(q, e);
    endtask
    // divisor upper before lower, since only lower reloads
    task automatic cfg(input logic [8:0] md, cb, cc, up, dl);
        wb(1'b1, OFS_MODE, md, q);
        wb(1'b1, OFS_CTRL_B, cb, q);
        wb(1'b1, OFS_CTRL_C, cc, q);
        wb(1'b1, OFS_DIV_UPPER, up, q);
        wb(1'b1, OFS_DIV_LOWER, dl, q);
    endtask
    task automatic rxc(input logic [8:0] cb, cc, ch, input int nb,
                       input logic sl, input logic [8:0] st);
        cfg(9'h000, cb, cc, 9'h000, 9'h000);
        remote.send(ch, nb, 16, sl);
        wb(1'b0, OFS_STATUS, 9'h000, q);
        chk(q & 9'h018, st);
        rd(OFS_DATA, ch);
        $display("test receive done");
    endtask
    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // tests take about 50k cycles; cut off at 100k
    initial begin
        #400000;
        n_mismatch++;
        close_out;
    end
    // ========
    // tests
    initial begin
        repeat (10) @(posedge mclk);
        sysRst <= 1'b0;
        rd(OFS_MODE, 9'h000);
        rd(OFS_CTRL_C, 9'h006);
        rd(OFS_DIV_LOWER, 9'h000);
        rd(8'h1C, 9'h000);
        wb(1'b1, OFS_DIV_UPPER, 9'h0F3, q);
        rd(OFS_DIV_UPPER, 9'h003);
        $display("test registers done");
        for (int k = 0; k < 5; k++) begin
            cfg(9'h000, {6'h01, cs[k][2], 2'h0}, {6'h00, cs[k][1:0], 1'b0},
                9'h000, 9'h000);
            wb(1'b1, OFS_DATA, 9'h155, q);
            remote.recv(ln[k], got, per, t0, stp);
            chk(got, 9'h155 & (9'h1FF >> (4'h9 - ln[k])));
            chk(per, 16);
            chk(stp, 1'b1);
            repeat (per) @(posedge mclk);
        end
        $display("test sizes done");
        for (int k = 0; k < 3; k++) begin
            cfg({7'h00, dbl[k], 1'b0}, 9'h008, {5'h00, sb[k], 3'h6},
                9'h000, lo[k]);
            wb(1'b1, OFS_DATA, 9'h0A5, q);
            fork
                remote.recv(8, got, per, t0, stp);
                begin
                    wait (txdPin === 1'b0);
                    wb(1'b1, OFS_DATA, 9'h0C3, q);
                end
            join
            remote.recv(8, got, per, t1, stp);
            chk(got, 9'h0C3);
            chk(per, ex[k]);
            chk(t1 - t0, (10 + sb[k]) * ex[k]);
            repeat (per) @(posedge mclk);
        end
        $display("test rates done");
        cfg(9'h002, 9'h008, 9'h006, 9'h000, 9'h002);
        wb(1'b1, OFS_DIV_UPPER, 9'h001, q);
        wb(1'b1, OFS_DATA, 9'h0A5, q);
        remote.recv(8, got, per, t0, stp);
        // upper alone waits for the running count, then (0x102+1)*8
        chk(per, 2072);
        repeat (per) @(posedge mclk);
        wb(1'b1, OFS_DIV_LOWER, 9'h000, q);
        wb(1'b1, OFS_DATA, 9'h0A5, q);
        remote.recv(8, got, per, t0, stp);
        chk(per, 2056);
        repeat (per) @(posedge mclk);
        $display("test reload done");
        rxc(9'h010, 9'h006, 9'h0A5, 8, 1'b1, 9'h008);
        rxc(9'h010, 9'h006, 9'h05A, 8, 1'b0, 9'h018);
        rxc(9'h014, 9'h00E, 9'h1C3, 9, 1'b1, 9'h008);
        for (int p = 0; p < 2; p++) begin
            cfg(9'h000, 9'h008, 9'h046 | 9'(p), 9'h000, 9'h001);
            chk(sclkOe, 1'b1);
            chk(txdOe, 1'b1);
            wb(1'b1, OFS_DATA, 9'h05B, q);
            remote.srecv(1'(p), 8, got);
            chk(got, 9'h05B);
            repeat (16) @(posedge mclk);
        end
        // polarity back to zero for async use
        cfg(9'h000, 9'h000, 9'h006, 9'h000, 9'h000);
        chk(sclkOe, 1'b0);
        $display("test sync done");
        close_out;
    end
endmodule
`default_nettype wire
